/* hw/uscr_pkg.sv */
// uscr_pkg: offsets, field positions and reset values of the uart shadow registers
// assumes: used by the shadow register block, its storage module, the assertions and the test
`default_nettype none
package uscr_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SHADOW_RTS = 8'h8c;
   localparam logic [7:0] OFS_SHADOW_BREAK = 8'h90;
   localparam logic [7:0] OFS_SHADOW_DMA_MODE = 8'h94;
   localparam logic [7:0] OFS_SHADOW_RX_TRIG = 8'h9c;
   localparam logic [7:0] OFS_SHADOW_TX_TRIG = 8'ha0;
   localparam logic [7:0] OFS_HALT_TX = 8'ha4;
   localparam logic [7:0] OFS_DMA_SOFT_ACK = 8'ha8;
   localparam logic [7:0] OFS_COMP_PARAMS = 8'hf4;
   // main control registers sharing the same state
   localparam logic [7:0] OFS_LINE_CONTROL = 8'h0c;
   localparam logic [7:0] OFS_MODEM_CONTROL = 8'h10;
   localparam logic [7:0] OFS_FIFO_CONTROL = 8'h08;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int MODEM_RTS_BIT = 1;
   localparam int LINE_BREAK_BIT = 6;
   localparam int FIFO_DMA_BIT = 3;
   localparam int FIFO_TXT_LO = 4;
   localparam int FIFO_RXT_LO = 6;
   localparam int PARAM_DEPTH_LO = 16;
   localparam int PARAM_SHADOW_BIT = 11;
   localparam int PARAM_TXMODE_BIT = 5;
   localparam int PARAM_XHSK_BIT = 13;
   localparam int PARAM_WIDTH_LO = 0;
   localparam logic [1:0] PARAM_WIDTH_32 = 2'h2;
   // ---------------------------------------------------------------
   // reset values and bus encodings
   // ---------------------------------------------------------------
   localparam logic RST_BIT = 1'h0;
   localparam logic [1:0] RST_TRIG = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // rx trigger encodings
   typedef enum logic [1:0] {
      USCR_RXT_ONE = 2'b00,
      USCR_RXT_QUARTER = 2'b01,
      USCR_RXT_HALF = 2'b10,
      USCR_RXT_TWO_LESS = 2'b11
   } uscr_rx_trig_t;
   // tx empty trigger encodings
   typedef enum logic [1:0] {
      USCR_TXT_EMPTY = 2'b00,
      USCR_TXT_TWO = 2'b01,
      USCR_TXT_QUARTER = 2'b10,
      USCR_TXT_HALF = 2'b11
   } uscr_tx_trig_t;
endpackage : uscr_pkg
`default_nettype wire

/* hw/uscr_wr_if.sv */
// uscr_wr_if: decoded register write bundle between bus slave and storage
// assumes: one clock, driven by the bus front end only
`default_nettype none
interface uscr_wr_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   modport src (output wr_en, output wr_addr, output wr_data);
   modport dst (input wr_en, input wr_addr, input wr_data);
endinterface : uscr_wr_if
`default_nettype wire

/* hw/uscr_store.sv */
// uscr_store: the single storage element per shared control field
// assumes: writes arrive as decoded one-cycle pulses on the bundle
`default_nettype none
module uscr_store #(
   parameter bit HAS_FIFO = 1'b1,
   parameter bit HAS_SHADOW = 1'b1,
   parameter bit HAS_THRE_USER = 1'b1,
   parameter bit HAS_EXTRA_HSK = 1'b1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // writes
   uscr_wr_if.dst wr,
   // stored fields
   output logic rts_q,
   output logic break_q,
   output logic dma_mode_q,
   output logic [1:0] rx_trig_q,
   output logic [1:0] tx_trig_q,
   output logic halt_q,
   output logic dma_ack_q
);
   localparam bit SH_FIFO = HAS_FIFO && HAS_SHADOW;
   logic w_lcr, w_mcr, w_fcr;
   assign w_lcr = wr.wr_en && (wr.wr_addr == uscr_pkg::OFS_LINE_CONTROL);
   assign w_mcr = wr.wr_en && (wr.wr_addr == uscr_pkg::OFS_MODEM_CONTROL);
   assign w_fcr = wr.wr_en && (wr.wr_addr == uscr_pkg::OFS_FIFO_CONTROL);
   function automatic logic hit(input logic [7:0] ofs);
      hit = wr.wr_en && (wr.wr_addr == ofs);
   endfunction : hit

   // one flop each, written through either address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rts_q <= uscr_pkg::RST_BIT;
      end else if (w_mcr) begin
         rts_q <= wr.wr_data[uscr_pkg::MODEM_RTS_BIT];
      end else if (HAS_SHADOW && hit(uscr_pkg::OFS_SHADOW_RTS)) begin
         rts_q <= wr.wr_data[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         break_q <= uscr_pkg::RST_BIT;
      end else if (w_lcr) begin
         break_q <= wr.wr_data[uscr_pkg::LINE_BREAK_BIT];
      end else if (HAS_SHADOW && hit(uscr_pkg::OFS_SHADOW_BREAK)) begin
         break_q <= wr.wr_data[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_mode_q <= uscr_pkg::RST_BIT;
         rx_trig_q <= uscr_pkg::RST_TRIG;
      end else if (w_fcr && HAS_FIFO) begin
         dma_mode_q <= wr.wr_data[uscr_pkg::FIFO_DMA_BIT];
         rx_trig_q <= wr.wr_data[uscr_pkg::FIFO_RXT_LO +: 2];
      end else begin
         if (SH_FIFO && hit(uscr_pkg::OFS_SHADOW_DMA_MODE)) begin
            dma_mode_q <= wr.wr_data[0];
         end
         if (SH_FIFO && hit(uscr_pkg::OFS_SHADOW_RX_TRIG)) begin
            rx_trig_q <= wr.wr_data[1:0];
         end
      end
   end

   // without the programmable mode the field stays at reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_trig_q <= uscr_pkg::RST_TRIG;
      end else if (HAS_FIFO && HAS_THRE_USER) begin
         if (w_fcr) begin
            tx_trig_q <= wr.wr_data[uscr_pkg::FIFO_TXT_LO +: 2];
         end else if (HAS_SHADOW && hit(uscr_pkg::OFS_SHADOW_TX_TRIG)) begin
            tx_trig_q <= wr.wr_data[1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_q <= uscr_pkg::RST_BIT;
      end else if (HAS_FIFO && hit(uscr_pkg::OFS_HALT_TX)) begin
         halt_q <= wr.wr_data[0];
      end
   end

   // one-cycle ack pulse; not stored, reads back as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_ack_q <= uscr_pkg::RST_BIT;
      end else begin
         dma_ack_q <= HAS_EXTRA_HSK && hit(uscr_pkg::OFS_DMA_SOFT_ACK) && wr.wr_data[0];
      end
   end
endmodule : uscr_store
`default_nettype wire

/* hw/uscr_top.sv */
// uscr_top: uart shadow and auxiliary control registers on ahb-lite
// assumes: single slave, word transfers, hready from hreadyout
// Operation
// - rts shadow mirrors modem control bit
// - break shadow mirrors line control break
// - dma mode shadow, zero mode 0
// - two-bit rx trigger shadow, four levels
// - two-bit tx empty trigger shadow
// - tx trigger writes ignored without mode
// - dma and rx shadows need fifo, shadow
// - tx shadow needs fifo, mode, shadow
// - halt transmit stops fifo transmission
// - halt writes ignored without fifos
// - software ack ends current dma handshake
// - ack writes ignored without extra handshake
`default_nettype none
module uscr_top #(
   parameter bit HAS_FIFO = 1'b1,
   parameter bit HAS_SHADOW = 1'b1,
   parameter bit HAS_THRE_USER = 1'b1,
   parameter bit HAS_EXTRA_HSK = 1'b1,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // uart core controls
   output logic rts_ctl,
   output logic break_ctl,
   output logic dma_mode,
   output logic [1:0] rx_trigger,
   output logic [1:0] tx_empty_trigger,
   output logic halt_tx,
   output logic dma_soft_ack
);
   // ---------------------------------------------------------------
   // configuration checks
   // ---------------------------------------------------------------
   // depth code is depth/16, up to 2048 entries
   localparam logic [7:0] DEPTH_CODE = HAS_FIFO ? 8'(FIFO_DEPTH / 16) : 8'h00;
   generate
      if (HAS_FIFO && (FIFO_DEPTH < 16 || FIFO_DEPTH > 2048 || (FIFO_DEPTH % 16) != 0)) begin : g_bad
         $error("fifo depth must be a multiple of 16 from 16 to 2048");
      end
   endgenerate

   // ---------------------------------------------------------------
   // bus address phase capture
   // ---------------------------------------------------------------
   logic ap_q, ap_wr_q;
   logic [7:0] ap_addr_q;
   logic take;
   assign take = hsel && hready && (htrans == uscr_pkg::HTRANS_NONSEQ || htrans == 2'h3);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= 1'b0;
         ap_wr_q <= 1'b0;
         ap_addr_q <= 8'h00;
      end else if (hready) begin
         ap_q <= take;
         ap_wr_q <= take && hwrite;
         ap_addr_q <= haddr[7:0];
      end
   end

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   uscr_wr_if wr_bus ();
   assign wr_bus.wr_en = ap_wr_q;
   assign wr_bus.wr_addr = {ap_addr_q[7:2], 2'b00};
   assign wr_bus.wr_data = hwdata;

   logic rts_q, break_q, dma_mode_q, halt_q, dma_ack_q;
   logic [1:0] rx_trig_q, tx_trig_q;

   uscr_store #(
      .HAS_FIFO(HAS_FIFO),
      .HAS_SHADOW(HAS_SHADOW),
      .HAS_THRE_USER(HAS_THRE_USER),
      .HAS_EXTRA_HSK(HAS_EXTRA_HSK)
   ) u_store (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr(wr_bus),
      .rts_q(rts_q),
      .break_q(break_q),
      .dma_mode_q(dma_mode_q),
      .rx_trig_q(rx_trig_q),
      .tx_trig_q(tx_trig_q),
      .halt_q(halt_q),
      .dma_ack_q(dma_ack_q)
   );

   assign rts_ctl = rts_q;
   assign break_ctl = break_q;
   assign dma_mode = dma_mode_q;
   assign rx_trigger = rx_trig_q;
   assign tx_empty_trigger = tx_trig_q;
   assign halt_tx = halt_q;
   assign dma_soft_ack = dma_ack_q;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   logic [31:0] param_val;
   always_comb begin
      param_val = 32'h0000_0000;
      param_val[uscr_pkg::PARAM_DEPTH_LO +: 8] = DEPTH_CODE;
      param_val[uscr_pkg::PARAM_XHSK_BIT] = HAS_EXTRA_HSK;
      param_val[uscr_pkg::PARAM_SHADOW_BIT] = HAS_SHADOW;
      param_val[uscr_pkg::PARAM_TXMODE_BIT] = HAS_THRE_USER;
      param_val[uscr_pkg::PARAM_WIDTH_LO +: 2] = uscr_pkg::PARAM_WIDTH_32;
   end

   // reads see the flop directly, so a write shows on the next read
   logic [31:0] rd_val;
   logic [7:0] ra;
   assign ra = {ap_addr_q[7:2], 2'b00};
   always_comb begin
      rd_val = 32'h0000_0000;
      case (ra)
         uscr_pkg::OFS_SHADOW_RTS: rd_val[0] = HAS_SHADOW && rts_q;
         uscr_pkg::OFS_MODEM_CONTROL: rd_val[uscr_pkg::MODEM_RTS_BIT] = rts_q;
         uscr_pkg::OFS_SHADOW_BREAK: rd_val[0] = HAS_SHADOW && break_q;
         uscr_pkg::OFS_LINE_CONTROL: rd_val[uscr_pkg::LINE_BREAK_BIT] = break_q;
         uscr_pkg::OFS_SHADOW_DMA_MODE: rd_val[0] = HAS_FIFO && HAS_SHADOW && dma_mode_q;
         uscr_pkg::OFS_SHADOW_RX_TRIG: rd_val[1:0] = (HAS_FIFO && HAS_SHADOW) ? rx_trig_q : 2'b00;
         uscr_pkg::OFS_SHADOW_TX_TRIG: rd_val[1:0] = (HAS_FIFO && HAS_SHADOW && HAS_THRE_USER) ? tx_trig_q : 2'b00;
         uscr_pkg::OFS_HALT_TX: rd_val[0] = halt_q;
         uscr_pkg::OFS_COMP_PARAMS: rd_val = param_val;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // data phase read output, zero outside read phases
   assign hrdata = (ap_q && !ap_wr_q) ? rd_val : 32'h0000_0000;
endmodule : uscr_top
`default_nettype wire

/* verification/uscr_top_assertions.sv */
// uscr_top_assertions: bus and mirror checks on the shadow block ports
// assumes: bound to every uscr_top, one clock hclk
`default_nettype none
module uscr_top_assertions #(
   parameter bit HAS_EXTRA_HSK = 1'b1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // controls
   input wire logic rts_ctl,
   input wire logic break_ctl,
   input wire logic halt_tx,
   input wire logic dma_soft_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic take = hsel && hready && htrans[1];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // address phase of a write, then its data phase
   sequence wr_s(a);
      take && hwrite && haddr[7:0] == a ##1 1'b1;
   endsequence
   ready_always_a: assert property (hreadyout == 1'b1)
      else $error("wait state seen");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   rdata_idle_a: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
      else $error("read data outside read data phase");
   rts_mirror_a: assert property (
      wr_s(uscr_pkg::OFS_MODEM_CONTROL) |=> rts_ctl == $past(hwdata[1]))
      else $error("rts not taken from modem control write");
   break_mirror_a: assert property (
      wr_s(uscr_pkg::OFS_SHADOW_BREAK) |=> break_ctl == $past(hwdata[0]))
      else $error("break not taken from shadow write");
   ack_cause_a: assert property (
      wr_s(uscr_pkg::OFS_DMA_SOFT_ACK) ##0 hwdata[0] |=> dma_soft_ack == HAS_EXTRA_HSK)
      else $error("soft ack pulse wrong after write");
   ack_single_a: assert property (dma_soft_ack |=> !dma_soft_ack)
      else $error("soft ack longer than one cycle");
   halt_hold_a: assert property (
      !$stable(halt_tx) |-> $past(take && hwrite && haddr[7:0] == uscr_pkg::OFS_HALT_TX, 2))
      else $error("halt changed without a write");
endmodule : uscr_top_assertions
bind uscr_top uscr_top_assertions #(.HAS_EXTRA_HSK(HAS_EXTRA_HSK)) uscr_top_assertions_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .rts_ctl(rts_ctl), .break_ctl(break_ctl), .halt_tx(halt_tx), .dma_soft_ack(dma_soft_ack));
`default_nettype wire

/* verification/test_uscr_top.sv */
// test_uscr_top: register-level test of the uart shadow registers
// assumes: this file is the only bus master, second instance lacks options
`default_nettype none
module test_uscr_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hsel2, hwrite, hreadyout, hresp, rts_ctl, break_ctl;
   logic dma_mode, halt_tx, dma_soft_ack, halt2, ack2, alt;
   logic [1:0] htrans, rx_trigger, tx_empty_trigger, txt2;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, hrdata2, rd_s, r;
   int err_total, n_checks;
   wire logic hready = hreadyout;
   localparam logic [7:0] OFS [8] = '{8'h8c, 8'h90, 8'h94, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'h80};
   uscr_top uscr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rts_ctl(rts_ctl), .break_ctl(break_ctl), .dma_mode(dma_mode),
      .rx_trigger(rx_trigger), .tx_empty_trigger(tx_empty_trigger), .halt_tx(halt_tx),
      .dma_soft_ack(dma_soft_ack));
   uscr_top #(.HAS_FIFO(1'b0), .HAS_THRE_USER(1'b0), .HAS_EXTRA_HSK(1'b0)) uscr_top_i2 (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel2), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(), .hresp(), .hrdata(hrdata2), .rts_ctl(),
      .break_ctl(), .dma_mode(), .rx_trigger(), .tx_empty_trigger(txt2), .halt_tx(halt2),
      .dma_soft_ack(ack2));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // read data captured at the edge that ends the data phase
   always @(posedge hclk) rd_s <= alt ? hrdata2 : hrdata;
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= !alt;
      hsel2 <= alt;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= uscr_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      #1 r = rd_s;
   endtask : bus
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rdc
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   initial begin
      {hsel, hsel2, hwrite, alt, hresetn, htrans, haddr, hwdata} = '0;
      hsize = uscr_pkg::HSIZE_WORD;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (OFS[i]) rdc(OFS[i], 32'h0);
      chk({rts_ctl, break_ctl, dma_mode, rx_trigger, tx_empty_trigger, halt_tx}, 32'h0);
      rdc(uscr_pkg::OFS_COMP_PARAMS, 32'h0001_2822);
      bus(1'b1, uscr_pkg::OFS_SHADOW_RTS, 32'hffff_ffff);
      chk(rts_ctl, 1'b1);
      rdc(uscr_pkg::OFS_MODEM_CONTROL, 32'h2);
      bus(1'b1, uscr_pkg::OFS_MODEM_CONTROL, 32'h0);
      rdc(uscr_pkg::OFS_SHADOW_RTS, 32'h0);
      bus(1'b1, uscr_pkg::OFS_LINE_CONTROL, 32'h40);
      rdc(uscr_pkg::OFS_SHADOW_BREAK, 32'h1);
      chk(break_ctl, 1'b1);
      bus(1'b1, uscr_pkg::OFS_SHADOW_BREAK, 32'h0);
      rdc(uscr_pkg::OFS_LINE_CONTROL, 32'h0);
      for (int v = 0; v < 4; v++) begin
         bus(1'b1, uscr_pkg::OFS_SHADOW_RX_TRIG, 32'hffff_fffc | v);
         rdc(uscr_pkg::OFS_SHADOW_RX_TRIG, v);
         bus(1'b1, uscr_pkg::OFS_SHADOW_TX_TRIG, 32'hffff_fffc | v);
         rdc(uscr_pkg::OFS_SHADOW_TX_TRIG, v);
         bus(1'b1, uscr_pkg::OFS_SHADOW_DMA_MODE, 32'hffff_fffe | v);
         rdc(uscr_pkg::OFS_SHADOW_DMA_MODE, v & 1);
         chk({rx_trigger, tx_empty_trigger, dma_mode}, {v[1:0], v[1:0], v[0]});
         // fifo control: rx trigger at 7:6, tx trigger at 5:4, dma mode at 3
         bus(1'b1, uscr_pkg::OFS_FIFO_CONTROL, (3 - v) * 32'h50 | ((v & 1) ^ 1) * 8);
         chk({rx_trigger, tx_empty_trigger, dma_mode}, {2'(3 - v), 2'(3 - v), !v[0]});
         rdc(uscr_pkg::OFS_SHADOW_RX_TRIG, 32'(3 - v));
      end
      bus(1'b1, uscr_pkg::OFS_HALT_TX, 32'h1);
      rdc(uscr_pkg::OFS_HALT_TX, 32'h1);
      chk(halt_tx, 1'b1);
      bus(1'b1, uscr_pkg::OFS_HALT_TX, 32'h0);
      chk(halt_tx, 1'b0);
      bus(1'b1, uscr_pkg::OFS_DMA_SOFT_ACK, 32'h1);
      chk(dma_soft_ack, 1'b1);
      rdc(uscr_pkg::OFS_DMA_SOFT_ACK, 32'h0);
      bus(1'b1, uscr_pkg::OFS_DMA_SOFT_ACK, 32'h0);
      chk(dma_soft_ack, 1'b0);
      bus(1'b1, 8'h80, 32'hffff_ffff);
      rdc(8'h80, 32'h0);
      chk(hresp, 1'b0);
      // second instance: no fifo, no programmable tx empty, no extra handshake
      alt = 1'b1;
      bus(1'b1, uscr_pkg::OFS_HALT_TX, 32'h1);
      chk(halt2, 1'b0);
      bus(1'b1, uscr_pkg::OFS_SHADOW_TX_TRIG, 32'h3);
      chk(txt2, 2'h0);
      bus(1'b1, uscr_pkg::OFS_DMA_SOFT_ACK, 32'h1);
      chk(ack2, 1'b0);
      bus(1'b1, uscr_pkg::OFS_SHADOW_RX_TRIG, 32'h3);
      rdc(uscr_pkg::OFS_SHADOW_RX_TRIG, 32'h0);
      end_sim();
   end
endmodule : test_uscr_top
`default_nettype wire
